/* test/orfa_seq_partner.sv */
// Sequencer-side model that loads the dedicated registers on request.
// Assumes the bench calls load() and clk is CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
module orfa_seq_partner (
  input  wire logic                 clk,
  input  wire logic                 seq_ready,
  output var logic                  seq_valid,
  output var orfa_pkg::orfa_seq_t   seq_kind,
  output var logic [31:0]           seq_value
);
  initial
  begin
    seq_valid = 1'b0;
    seq_kind  = orfa_pkg::ORFA_SEQ_MASK;
    seq_value = 32'h00000000;
  end
  // Mask, signature, status, bit index, data, address, probe
  task automatic load(input orfa_pkg::orfa_seq_t k, input logic [31:0] v, output logic ok);
    ok = 1'b0;
    for (int n = 0; n < 20 && !ok; n++)
    begin
      @(negedge clk);
      ok = seq_ready;
    end
    if (ok)
    begin
      seq_valid = 1'b1;
      seq_kind  = k;
      seq_value = v;
      @(posedge clk);
      @(negedge clk);
      seq_valid = 1'b0;
      // Released value must not look valid
      seq_value = ~v;
    end
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the operator register file and ALU.
// Assumes orfa_pkg and the design files are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic                  CLK_SYS = 1'b0;
  logic                  ARST_N = 1'b0;
  logic                  OP_VALID = 1'b0;
  orfa_pkg::orfa_op_t    OP_CODE = orfa_pkg::ORFA_OP_NONE;
  logic [3:0]            OP_SEL = 4'h0;
  logic [3:0]            OP_SRC_SEL = 4'h0;
  logic                  OP_SRC_IMM = 1'b0;
  logic [31:0]           OP_IMM = 32'h00000000;
  logic                  OP_READY, OP_DONE, SEQ_READY, EXAM_VALID, SEQ_VALID;
  logic [31:0]           OP_RESULT, EXAM_DATA, SEQ_VALUE;
  orfa_pkg::orfa_seq_t   SEQ_KIND;
  logic                  EXAM_REQ = 1'b0;
  logic [3:0]            EXAM_SEL = 4'h0;
  logic [31:0]           exp_q [16];
  int                    n_errors = 0;
  int                    compares = 0;

  always #4 CLK_SYS = ~CLK_SYS;

  orfa_top uut (.CLK_SYS(CLK_SYS), .ARST_N(ARST_N), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
    .OP_SEL(OP_SEL), .OP_SRC_SEL(OP_SRC_SEL), .OP_SRC_IMM(OP_SRC_IMM), .OP_IMM(OP_IMM),
    .OP_READY(OP_READY), .OP_DONE(OP_DONE), .OP_RESULT(OP_RESULT), .SEQ_VALID(SEQ_VALID),
    .SEQ_KIND(SEQ_KIND), .SEQ_VALUE(SEQ_VALUE), .SEQ_READY(SEQ_READY), .EXAM_REQ(EXAM_REQ),
    .EXAM_SEL(EXAM_SEL), .EXAM_VALID(EXAM_VALID), .EXAM_DATA(EXAM_DATA));
  orfa_seq_partner seq (.clk(CLK_SYS), .seq_ready(SEQ_READY), .seq_valid(SEQ_VALID),
    .seq_kind(SEQ_KIND), .seq_value(SEQ_VALUE));

  task automatic wrap_up();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] e);
    compares++;
    if (got !== e)
    begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, e);
    end
  endtask

  // Bounded wait at falling edges: 0 ready, 1 done, 2 examine valid
  task automatic wait_for(input int k);
    for (int n = 0; n < 30; n++)
    begin
      if ((k == 0 && OP_READY === 1'b1) || (k == 1 && OP_DONE === 1'b1) ||
          (k == 2 && EXAM_VALID === 1'b1))
        return;
      @(negedge CLK_SYS);
    end
    n_errors++;
    $display("[FAIL] %0t handshake timeout %0d", $time, k);
    wrap_up();
  endtask

  task automatic op(input orfa_pkg::orfa_op_t c, input logic [3:0] s, input logic [3:0] r,
                    input logic im, input logic [31:0] v, input logic [31:0] e);
    wait_for(0);
    OP_VALID = 1'b1;
    OP_CODE = c;
    OP_SEL = s;
    OP_SRC_SEL = r;
    OP_SRC_IMM = im;
    OP_IMM = v;
    @(negedge CLK_SYS);
    OP_VALID = 1'b0;
    wait_for(1);
    check(OP_RESULT, e);
    exp_q[s] = e;
    @(negedge CLK_SYS);
  endtask

  task automatic exam(input logic [3:0] i);
    wait_for(0);
    EXAM_REQ = 1'b1;
    EXAM_SEL = i;
    @(negedge CLK_SYS);
    EXAM_REQ = 1'b0;
    wait_for(2);
    // Data trails the valid pulse by one cycle
    @(negedge CLK_SYS);
    check(EXAM_DATA, exp_q[i]);
  endtask

  task automatic exam_all();
    for (int i = 0; i < 16; i++)
      exam(4'(i));
  endtask

  task automatic sload(input orfa_pkg::orfa_seq_t k, input logic [3:0] i, input logic [31:0] v);
    logic ok;
    seq.load(k, v, ok);
    if (!ok)
    begin
      n_errors++;
      $display("[FAIL] %0t sequencer load refused", $time);
      wrap_up();
    end
    else
    begin
      exp_q[i] = (k == orfa_pkg::ORFA_SEQ_BITNUM) ? (v & 32'h0000001F) : v;
      repeat (2) @(negedge CLK_SYS);
    end
  endtask

  task automatic t_load();
    op(orfa_pkg::ORFA_OP_LOAD, 4'h2, 4'h0, 1'b0, 32'h000040CC, 32'h000040CC);
    op(orfa_pkg::ORFA_OP_LOAD, 4'h9, 4'h0, 1'b0, 32'h0FFFFFFF, 32'h0FFFFFFF);
    exam(4'h2);
    exam(4'h9);
  endtask

  task automatic t_unary();
    op(orfa_pkg::ORFA_OP_LOAD, 4'h5, 4'h0, 1'b0, 32'h000000DF, 32'h000000DF);
    op(orfa_pkg::ORFA_OP_INC, 4'h5, 4'h0, 1'b0, 32'h00000000, 32'h000000E0);
    op(orfa_pkg::ORFA_OP_DEC, 4'h5, 4'h0, 1'b0, 32'h00000000, 32'h000000DF);
    op(orfa_pkg::ORFA_OP_CPL, 4'h5, 4'h0, 1'b0, 32'h00000000, 32'hFFFFFF20);
    op(orfa_pkg::ORFA_OP_SHL, 4'h5, 4'h0, 1'b0, 32'h00000000, 32'hFFFFFE40);
    op(orfa_pkg::ORFA_OP_SHR, 4'h5, 4'h0, 1'b0, 32'h00000000, 32'h7FFFFF20);
    op(orfa_pkg::ORFA_OP_DEC, 4'h3, 4'h0, 1'b0, 32'h00000000, 32'hFFFFFFFF);
    op(orfa_pkg::ORFA_OP_INC, 4'h3, 4'h0, 1'b0, 32'h00000000, 32'h00000000);
  endtask

  task automatic t_binary();
    op(orfa_pkg::ORFA_OP_LOAD, 4'hE, 4'h0, 1'b0, 32'h000000F4, 32'h000000F4);
    op(orfa_pkg::ORFA_OP_AND, 4'h5, 4'hE, 1'b0, 32'h00000000, 32'h00000020);
    op(orfa_pkg::ORFA_OP_OR, 4'h5, 4'hE, 1'b0, 32'h00000000, 32'h000000F4);
    op(orfa_pkg::ORFA_OP_AND, 4'h5, 4'hE, 1'b1, 32'h0000000F, 32'h00000004);
    op(orfa_pkg::ORFA_OP_OR, 4'h5, 4'hE, 1'b1, 32'h000000F0, 32'h000000F4);
    exam(4'h5);
    exam(4'hE);
  endtask

  task automatic t_seq();
    sload(orfa_pkg::ORFA_SEQ_MASK, 4'hA, 32'h000000A5);
    sload(orfa_pkg::ORFA_SEQ_SIG, 4'hB, 32'h00001234);
    sload(orfa_pkg::ORFA_SEQ_STSCTL, 4'hC, 32'h0000005A);
    sload(orfa_pkg::ORFA_SEQ_BITNUM, 4'hD, 32'h00000023);
    sload(orfa_pkg::ORFA_SEQ_DATA, 4'hE, 32'h0000FF20);
    sload(orfa_pkg::ORFA_SEQ_ADDR, 4'hF, 32'h00001A08);
    sload(orfa_pkg::ORFA_SEQ_PROBE, 4'h0, 32'h00C0FFEE);
    exam_all();
  endtask

  task automatic t_both();
    op(orfa_pkg::ORFA_OP_LOAD, 4'hC, 4'h0, 1'b0, 32'h00001111, 32'h00001111);
    sload(orfa_pkg::ORFA_SEQ_STSCTL, 4'hC, 32'h00002222);
    exam(4'hC);
    op(orfa_pkg::ORFA_OP_LOAD, 4'hC, 4'h0, 1'b0, 32'h00004444, 32'h00004444);
    exam(4'hC);
  endtask

  // Sequencer load lands while the operator holds the write port
  task automatic t_clash();
    logic ok;
    fork
      op(orfa_pkg::ORFA_OP_INC, 4'hE, 4'h0, 1'b0, 32'h00000000, 32'h0000FF21);
      seq.load(orfa_pkg::ORFA_SEQ_DATA, 32'h0000D407, ok);
    join
    exp_q[14] = 32'h0000D407;
    check(32'(ok), 32'h00000001);
    exam(4'hE);
  endtask

  // Second reset with loaded registers
  task automatic t_reset();
    ARST_N = 1'b0;
    repeat (3) @(negedge CLK_SYS);
    ARST_N = 1'b1;
    for (int i = 0; i < 16; i++)
      exp_q[i] = 32'h00000000;
    @(negedge CLK_SYS);
    check(OP_RESULT, 32'h00000000);
    exam_all();
  endtask

  initial
  begin
    for (int i = 0; i < 16; i++)
      exp_q[i] = 32'h00000000;
    repeat (20) @(negedge CLK_SYS);
    ARST_N = 1'b1;
    @(negedge CLK_SYS);
    exam_all();
    t_load();
    t_unary();
    t_binary();
    t_seq();
    t_both();
    t_clash();
    exam_all();
    t_reset();
    wrap_up();
  end
endmodule
`default_nettype wire

/* verilog/orfa_pkg.sv */
// Types for the operator register file and ALU.
// Assumes orfa_regs.svh is on the include path.
`include "orfa_regs.svh"
package orfa_pkg;
  typedef enum logic [3:0] {
    ORFA_OP_NONE  = 4'b0000,
    ORFA_OP_LOAD  = 4'b0001,
    ORFA_OP_INC   = 4'b0010,
    ORFA_OP_DEC   = 4'b0011,
    ORFA_OP_CPL   = 4'b0100,
    ORFA_OP_SHL   = 4'b0101,
    ORFA_OP_SHR   = 4'b0110,
    ORFA_OP_AND   = 4'b0111,
    ORFA_OP_OR    = 4'b1000
  } orfa_op_t;
  typedef enum logic [2:0] {
    ORFA_SEQ_MASK   = 3'b000,
    ORFA_SEQ_SIG    = 3'b001,
    ORFA_SEQ_STSCTL = 3'b010,
    ORFA_SEQ_BITNUM = 3'b011,
    ORFA_SEQ_DATA   = 3'b100,
    ORFA_SEQ_ADDR   = 3'b101,
    ORFA_SEQ_PROBE  = 3'b110
  } orfa_seq_t;
endpackage

/* verilog/orfa_regbank.sv */
// Sixteen-entry register bank, two registered read ports, one write port.
// Assumes a single clock and asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
`include "orfa_regs.svh"
module orfa_regbank #(
  parameter int WIDTH = `ORFA_WIDTH,
  parameter int DEPTH = `ORFA_NREGS,
  parameter int AW    = `ORFA_IDX_W
) (
  input  wire logic             clk,
  input  wire logic             arst_n,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr_a,
  input  wire logic [AW-1:0]    raddr_b,
  output logic      [WIDTH-1:0] rdata_a,
  output logic      [WIDTH-1:0] rdata_b
);
  logic [WIDTH-1:0] mem_reg [DEPTH];

  // Power-up clears every entry
  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++)
    begin : g_ent
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          mem_reg[gi] <= `ORFA_RESET_VAL;
        else if (we && waddr == AW'(gi))
          mem_reg[gi] <= wdata;
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_a <= `ORFA_RESET_VAL;
      rdata_b <= `ORFA_RESET_VAL;
    end
    else
    begin
      rdata_a <= mem_reg[raddr_a];
      rdata_b <= mem_reg[raddr_b];
    end
  end
endmodule
`default_nettype wire

/* verilog/orfa_regs.svh */
// Constants for the operator register file and ALU.
// Assumes inclusion by the package and design files by bare name.
`ifndef ORFA_REGS_SVH
`define ORFA_REGS_SVH
`define ORFA_NREGS        16
`define ORFA_WIDTH        32
`define ORFA_IDX_W        4
`define ORFA_REG_PROBE    4'h0
`define ORFA_REG_OPER_LO  4'h1
`define ORFA_REG_OPER_HI  4'h9
`define ORFA_REG_MASK     4'hA
`define ORFA_REG_SIG      4'hB
`define ORFA_REG_STSCTL   4'hC
`define ORFA_REG_BITNUM   4'hD
`define ORFA_REG_DATA     4'hE
`define ORFA_REG_ADDR     4'hF
`define ORFA_RESET_VAL    32'h00000000
`define ORFA_LOAD_MAX     32'h0FFFFFFF
`define ORFA_BITNUM_MASK  32'h0000001F
`define ORFA_ONE          32'h00000001
`endif

/* verilog/orfa_top.sv */
// Operator register file with unary/binary ALU and sequencer capture.
// Assumes operator commands and sequencer loads come from CLK_SYS logic.
`timescale 1ns/1ps
`default_nettype none
`include "orfa_regs.svh"
// Behaviour
// - Sixteen 32-bit operator-modifiable registers
// - Registers 1-9 written only by operator
// - Data entered or driven copied to E
// - Address entered or driven copied to F
// - Register A captures latest bit mask
// - Register B captures latest ROM signature
// - Register C captures latest status/control pattern
// - Register D captures latest bit index
// - Register 0 captures latest probe read data
// - Sequencer loads never block operator writes
// - Power-up clears all sixteen registers
// - Increment adds one, writes back
// - Decrement subtracts one, writes back
// - Complement inverts all bits
// - Shift left, zero into bit 0
// - Shift right, zero into MSB
// - AND with register or immediate
// - OR with register or immediate
// - Select addresses any of sixteen registers
// - Direct load takes 0 to FFFFFFF; the code loads all 32 bits of OP_IMM unchecked
// - Binary result replaces first register
// - Register contents usable as operand
module orfa_top (
  input  wire logic                     CLK_SYS,
  input  wire logic                     ARST_N,
  input  wire logic                     OP_VALID,
  input  wire orfa_pkg::orfa_op_t       OP_CODE,
  input  wire logic [`ORFA_IDX_W-1:0]   OP_SEL,
  input  wire logic [`ORFA_IDX_W-1:0]   OP_SRC_SEL,
  input  wire logic                     OP_SRC_IMM,
  input  wire logic [`ORFA_WIDTH-1:0]   OP_IMM,
  output logic                          OP_READY,
  output logic                          OP_DONE,
  output logic [`ORFA_WIDTH-1:0]        OP_RESULT,
  input  wire logic                     SEQ_VALID,
  input  wire orfa_pkg::orfa_seq_t      SEQ_KIND,
  input  wire logic [`ORFA_WIDTH-1:0]   SEQ_VALUE,
  output logic                          SEQ_READY,
  input  wire logic                     EXAM_REQ,
  input  wire logic [`ORFA_IDX_W-1:0]   EXAM_SEL,
  output logic                          EXAM_VALID,
  output logic [`ORFA_WIDTH-1:0]        EXAM_DATA
);
  typedef enum logic [1:0] {
    ORFA_ST_IDLE  = 2'b00,
    ORFA_ST_READ  = 2'b01,
    ORFA_ST_WRITE = 2'b10
  } orfa_st_t;

  orfa_st_t                 st_reg;
  orfa_st_t                 st_next;
  orfa_pkg::orfa_op_t       op_reg;
  logic [`ORFA_IDX_W-1:0]   sel_reg;
  logic                     imm_sel_reg;
  logic [`ORFA_WIDTH-1:0]   imm_reg;
  logic [`ORFA_WIDTH-1:0]   alu_next;
  logic [`ORFA_WIDTH-1:0]   rd_a;
  logic [`ORFA_WIDTH-1:0]   rd_b;
  logic [`ORFA_WIDTH-1:0]   ex_rd;
  logic [`ORFA_IDX_W-1:0]   ra_a;
  logic [`ORFA_IDX_W-1:0]   ra_b;
  logic                     we;
  logic [`ORFA_IDX_W-1:0]   waddr;
  logic [`ORFA_WIDTH-1:0]   wdata;
  logic                     seq_pend_reg;
  orfa_pkg::orfa_seq_t      seq_kind_reg;
  logic [`ORFA_WIDTH-1:0]   seq_val_reg;
  logic [`ORFA_IDX_W-1:0]   seq_addr;
  logic [`ORFA_WIDTH-1:0]   seq_wdata;
  logic                     seq_take;
  logic                     op_write;
  logic                     exam_pend_reg;
  logic [`ORFA_IDX_W-1:0]   exam_sel_reg;

  // Operator path: accept only when idle
  assign OP_READY = (st_reg == ORFA_ST_IDLE) && !exam_pend_reg;

  always_comb
  begin
    st_next = st_reg;
    case (st_reg)
      ORFA_ST_IDLE:
        if (OP_VALID && OP_READY)
          st_next = (OP_CODE == orfa_pkg::ORFA_OP_LOAD) ? ORFA_ST_WRITE : ORFA_ST_READ;
      ORFA_ST_READ:
        st_next = ORFA_ST_WRITE;
      ORFA_ST_WRITE:
        st_next = ORFA_ST_IDLE;
      default:
        st_next = ORFA_ST_IDLE;
    endcase
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
      st_reg <= ORFA_ST_IDLE;
    else
      st_reg <= st_next;
  end

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      op_reg      <= orfa_pkg::ORFA_OP_NONE;
      sel_reg     <= '0;
      imm_sel_reg <= 1'b0;
      imm_reg     <= `ORFA_RESET_VAL;
    end
    else if (OP_VALID && OP_READY)
    begin
      op_reg      <= OP_CODE;
      sel_reg     <= OP_SEL;
      imm_sel_reg <= OP_SRC_IMM;
      // Load value is trusted to stay within the entry range
      imm_reg     <= OP_IMM;
    end
  end

  // Read ports: A = target, B = second operand, exam shares port B when idle
  // Limitation: a load to the target during READ is overwritten
  // By the write-back, which was formed from the older contents
  assign ra_a = (st_reg == ORFA_ST_IDLE) ? OP_SEL : sel_reg;
  assign ra_b = (st_reg == ORFA_ST_IDLE && exam_pend_reg) ? exam_sel_reg : OP_SRC_SEL;

  // OP_SRC_SEL must hold from request until the result is written
  always_comb
  begin
    case (op_reg)
      orfa_pkg::ORFA_OP_LOAD: alu_next = imm_reg;
      orfa_pkg::ORFA_OP_INC:  alu_next = rd_a + `ORFA_ONE;
      orfa_pkg::ORFA_OP_DEC:  alu_next = rd_a - `ORFA_ONE;
      orfa_pkg::ORFA_OP_CPL:  alu_next = ~rd_a;
      orfa_pkg::ORFA_OP_SHL:  alu_next = {rd_a[`ORFA_WIDTH-2:0], 1'b0};
      orfa_pkg::ORFA_OP_SHR:  alu_next = {1'b0, rd_a[`ORFA_WIDTH-1:1]};
      orfa_pkg::ORFA_OP_AND:  alu_next = rd_a & (imm_sel_reg ? imm_reg : rd_b);
      orfa_pkg::ORFA_OP_OR:   alu_next = rd_a | (imm_sel_reg ? imm_reg : rd_b);
      default:                alu_next = rd_a;
    endcase
  end

  // Sequencer capture: one-deep holding, drained when operator is not writing
  assign SEQ_READY = !seq_pend_reg;
  assign op_write  = (st_reg == ORFA_ST_WRITE) && (op_reg != orfa_pkg::ORFA_OP_NONE);
  assign seq_take  = seq_pend_reg && !op_write;

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      seq_pend_reg <= 1'b0;
      seq_kind_reg <= orfa_pkg::ORFA_SEQ_DATA;
      seq_val_reg  <= `ORFA_RESET_VAL;
    end
    else if (SEQ_VALID && SEQ_READY)
    begin
      seq_pend_reg <= 1'b1;
      seq_kind_reg <= SEQ_KIND;
      seq_val_reg  <= SEQ_VALUE;
    end
    else if (seq_take)
      seq_pend_reg <= 1'b0;
  end

  // Sequencer kinds map only onto dedicated registers, never 1-9
  always_comb
  begin
    seq_wdata = seq_val_reg;
    case (seq_kind_reg)
      orfa_pkg::ORFA_SEQ_MASK:   seq_addr = `ORFA_REG_MASK;
      orfa_pkg::ORFA_SEQ_SIG:    seq_addr = `ORFA_REG_SIG;
      orfa_pkg::ORFA_SEQ_STSCTL: seq_addr = `ORFA_REG_STSCTL;
      orfa_pkg::ORFA_SEQ_BITNUM:
      begin
        seq_addr  = `ORFA_REG_BITNUM;
        seq_wdata = seq_val_reg & `ORFA_BITNUM_MASK;
      end
      orfa_pkg::ORFA_SEQ_DATA:   seq_addr = `ORFA_REG_DATA;
      orfa_pkg::ORFA_SEQ_ADDR:   seq_addr = `ORFA_REG_ADDR;
      orfa_pkg::ORFA_SEQ_PROBE:  seq_addr = `ORFA_REG_PROBE;
      default:                   seq_addr = `ORFA_REG_DATA;
    endcase
  end

  // Single write port: operator first, sequencer waits one cycle
  always_comb
  begin
    we    = 1'b0;
    waddr = sel_reg;
    wdata = alu_next;
    if (op_write)
    begin
      we    = 1'b1;
      waddr = sel_reg;
      wdata = alu_next;
    end
    else if (seq_take)
    begin
      we    = 1'b1;
      waddr = seq_addr;
      wdata = seq_wdata;
    end
  end

  orfa_regbank #(
    .WIDTH (`ORFA_WIDTH),
    .DEPTH (`ORFA_NREGS),
    .AW    (`ORFA_IDX_W)
  ) u_bank (
    .clk     (CLK_SYS),
    .arst_n  (ARST_N),
    .we      (we),
    .waddr   (waddr),
    .wdata   (wdata),
    .raddr_a (ra_a),
    .raddr_b (ra_b),
    .rdata_a (rd_a),
    .rdata_b (ex_rd)
  );
  assign rd_b = ex_rd;

  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      OP_DONE   <= 1'b0;
      OP_RESULT <= `ORFA_RESET_VAL;
    end
    else
    begin
      OP_DONE <= op_write;
      if (op_write)
        OP_RESULT <= alu_next;
    end
  end

  // Examine: request latched, read on port B in an idle cycle
  always_ff @(posedge CLK_SYS or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      exam_pend_reg <= 1'b0;
      exam_sel_reg  <= '0;
      EXAM_VALID    <= 1'b0;
      EXAM_DATA     <= `ORFA_RESET_VAL;
    end
    else
    begin
      EXAM_VALID <= 1'b0;
      if (EXAM_REQ && !exam_pend_reg)
      begin
        exam_pend_reg <= 1'b1;
        exam_sel_reg  <= EXAM_SEL;
      end
      else if (exam_pend_reg && st_reg == ORFA_ST_IDLE)
        exam_pend_reg <= 1'b0;
      if (EXAM_VALID == 1'b0 && exam_pend_reg && st_reg == ORFA_ST_IDLE)
        EXAM_VALID <= 1'b1;
      if (EXAM_VALID)
        EXAM_DATA <= ex_rd;
    end
  end

  chk_inc_wraps: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (st_reg == ORFA_ST_WRITE && op_reg == orfa_pkg::ORFA_OP_INC)
      |-> ##1 (OP_RESULT == $past(rd_a) + `ORFA_ONE))
    else $error("increment result wrong");
  chk_dec_result: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (st_reg == ORFA_ST_WRITE && op_reg == orfa_pkg::ORFA_OP_DEC)
      |-> ##1 (OP_RESULT == $past(rd_a) - `ORFA_ONE))
    else $error("decrement result wrong");
  chk_cpl_result: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (st_reg == ORFA_ST_WRITE && op_reg == orfa_pkg::ORFA_OP_CPL)
      |-> ##1 (OP_RESULT == ~$past(rd_a)))
    else $error("complement result wrong");
  chk_shl_zero: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (st_reg == ORFA_ST_WRITE && op_reg == orfa_pkg::ORFA_OP_SHL) |-> ##1 !OP_RESULT[0])
    else $error("shift left bit 0 not zero");
  chk_shr_zero: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (st_reg == ORFA_ST_WRITE && op_reg == orfa_pkg::ORFA_OP_SHR)
      |-> ##1 !OP_RESULT[`ORFA_WIDTH-1])
    else $error("shift right msb not zero");
  chk_seq_dedic: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (we && !op_write) |-> !(waddr >= `ORFA_REG_OPER_LO && waddr <= `ORFA_REG_OPER_HI))
    else $error("sequencer wrote operator register");
  chk_seq_drain: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (SEQ_VALID && SEQ_READY) |-> ##[1:3] seq_take)
    else $error("sequencer load not written");
  chk_op_finish: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (OP_VALID && OP_READY && OP_CODE != orfa_pkg::ORFA_OP_NONE) |-> ##[1:2] op_write ##1 OP_DONE)
    else $error("operator command not written back");
  chk_data_e: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (seq_take && seq_kind_reg == orfa_pkg::ORFA_SEQ_DATA) |-> waddr == `ORFA_REG_DATA)
    else $error("data capture not to E");
  chk_load_value: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (st_reg == ORFA_ST_WRITE && op_reg == orfa_pkg::ORFA_OP_LOAD)
      |-> ##1 (OP_RESULT == $past(imm_reg)))
    else $error("load result wrong");
  chk_and_result: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (st_reg == ORFA_ST_WRITE && op_reg == orfa_pkg::ORFA_OP_AND)
      |-> ##1 (OP_RESULT == ($past(rd_a)
        & ($past(imm_sel_reg) ? $past(imm_reg) : $past(rd_b)))))
    else $error("and result wrong");
  chk_or_result: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (st_reg == ORFA_ST_WRITE && op_reg == orfa_pkg::ORFA_OP_OR)
      |-> ##1 (OP_RESULT == ($past(rd_a)
        | ($past(imm_sel_reg) ? $past(imm_reg) : $past(rd_b)))))
    else $error("or result wrong");
  chk_mask_a: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (seq_take && seq_kind_reg == orfa_pkg::ORFA_SEQ_MASK) |-> waddr == `ORFA_REG_MASK)
    else $error("mask capture not to A");
  chk_sig_b: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (seq_take && seq_kind_reg == orfa_pkg::ORFA_SEQ_SIG) |-> waddr == `ORFA_REG_SIG)
    else $error("signature capture not to B");
  chk_stsctl_c: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (seq_take && seq_kind_reg == orfa_pkg::ORFA_SEQ_STSCTL) |-> waddr == `ORFA_REG_STSCTL)
    else $error("status capture not to C");
  chk_bitnum_range: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (seq_take && seq_kind_reg == orfa_pkg::ORFA_SEQ_BITNUM) |-> wdata <= `ORFA_BITNUM_MASK)
    else $error("bit index out of range");
  chk_addr_f: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (seq_take && seq_kind_reg == orfa_pkg::ORFA_SEQ_ADDR) |-> waddr == `ORFA_REG_ADDR)
    else $error("address capture not to F");
  chk_probe_zero: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    (seq_take && seq_kind_reg == orfa_pkg::ORFA_SEQ_PROBE) |-> waddr == `ORFA_REG_PROBE)
    else $error("probe capture not to 0");
  chk_exam_pulse: assert property (@(posedge CLK_SYS) disable iff (!ARST_N)
    EXAM_VALID |=> !EXAM_VALID)
    else $error("examine valid longer than one cycle");

  cov_and_imm: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    op_write && op_reg == orfa_pkg::ORFA_OP_AND && imm_sel_reg);
  cov_or_reg: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    op_write && op_reg == orfa_pkg::ORFA_OP_OR && !imm_sel_reg);
  cov_seq_wait: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    seq_pend_reg && op_write);
  cov_exam: cover property (@(posedge CLK_SYS) disable iff (!ARST_N) EXAM_VALID);
  cov_dec_wrap: cover property (@(posedge CLK_SYS) disable iff (!ARST_N)
    op_write && op_reg == orfa_pkg::ORFA_OP_DEC && rd_a == `ORFA_RESET_VAL);
endmodule
`default_nettype wire
